// ---- cfg_regs_pkg.sv ----
// Behaviour
// - Start field selects threshold point nine..twelve
// - Long-range gain code is power-of-two multiplier
// - Long-range gain applies from start to end
// - Short-range gain applies before the start point
// - Checksum register is eight-bit read-write
// - Bit 7 dump enable, hardware may set
// - Unlock field 0xD enables programming
// - Bit 2 reads one after successful program
// - Writing bit 1 starts a reload
// - Writing bit 0 starts a program
// - Address 41h holds A2 high byte
// - Address 42h holds A2 low byte, reset zero
package cfg_regs_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_GAIN_CTRL   = 8'h2a;
  localparam logic [7:0] IDX_CHECKSUM    = 8'h2b;
  localparam logic [7:0] IDX_NVM_CTRL    = 8'h40;
  localparam logic [7:0] IDX_A2_HIGH     = 8'h41;
  localparam logic [7:0] IDX_A2_LOW      = 8'h42;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h50;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h51;
  localparam logic [7:0] IDX_THR_POINT   = 8'h52;

  // ==========================================================================
  // Field positions
  localparam int unsigned LR_START_LSB   = 6;
  localparam int unsigned LR_GAIN_LSB    = 3;
  localparam int unsigned SR_GAIN_LSB    = 0;
  localparam int unsigned DUMP_EN_BIT    = 7;
  localparam int unsigned UNLOCK_LSB     = 3;
  localparam int unsigned WRITE_OK_BIT   = 2;
  localparam int unsigned RELOAD_BIT     = 1;
  localparam int unsigned PROGRAM_BIT    = 0;

  // ==========================================================================
  // Values
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [3:0] UNLOCK_PASSCODE = 4'hd;
  localparam logic [3:0] FIRST_LR_POINT  = 4'h9;
  localparam logic [2:0] GAIN_CODE_MAX   = 3'h5;
  localparam logic [3:0] NVM_BUSY_CYCLES = 4'h8;

  // Interrupt status bits
  localparam int unsigned IRQ_PROG_DONE  = 0;
  localparam int unsigned IRQ_PROG_DENY  = 1;
  localparam int unsigned IRQ_RELOAD_DONE = 2;
  localparam int unsigned IRQ_BAD_GAIN   = 3;

  typedef enum logic [1:0] {
    NVM_IDLE   = 2'b00,
    NVM_PROG   = 2'b01,
    NVM_RELOAD = 2'b10
  } nvm_state_t;

  // Power-of-two multiplier, 1..32, saturated for invalid codes
  function automatic logic [5:0] gain_mult(input logic [2:0] code);
    logic [2:0] c;
    c = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
    gain_mult = 6'h01 << c;
  endfunction : gain_mult

endpackage : cfg_regs_pkg

// ---- gain_if.sv ----
`timescale 1ns/10ps
interface gain_if;
  logic [7:0] gain_ctrl;
  logic [3:0] thr_point;
  logic [5:0] mult;
  logic       long_range;
  modport src (output gain_ctrl, output thr_point,
               input mult, input long_range);
  modport sel (input gain_ctrl, input thr_point,
               output mult, output long_range);
endinterface : gain_if

// ---- gain_select.sv ----
`timescale 1ns/10ps
module gain_select
  import cfg_regs_pkg::*;
(
  gain_if.sel g
);
  logic [3:0] start_point;
  // Start point nine plus the two-bit code
  assign start_point = FIRST_LR_POINT
                       + {2'b00, g.gain_ctrl[LR_START_LSB +: 2]};
  // Long range from start point onward, short range before it
  assign g.long_range = (g.thr_point >= start_point);
  assign g.mult = g.long_range
                  ? gain_mult(g.gain_ctrl[LR_GAIN_LSB +: 3])
                  : gain_mult(g.gain_ctrl[SR_GAIN_LSB +: 3]);
endmodule : gain_select

// ---- nvm_sequencer.sv ----
`timescale 1ns/10ps
module nvm_sequencer
  import cfg_regs_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic prog_req_i,
  input  wire logic reload_req_i,
  input  wire logic unlocked_i,
  output logic      busy_o,
  output logic      prog_done_o,
  output logic      prog_deny_o,
  output logic      reload_done_o
);
  nvm_state_t state_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg     <= NVM_IDLE;
      cnt_reg       <= 4'h0;
      prog_done_o   <= 1'b0;
      prog_deny_o   <= 1'b0;
      reload_done_o <= 1'b0;
    end else begin
      prog_done_o   <= 1'b0;
      prog_deny_o   <= 1'b0;
      reload_done_o <= 1'b0;
      case (state_reg)
        NVM_IDLE: begin
          cnt_reg <= NVM_BUSY_CYCLES;
          if (prog_req_i && unlocked_i) begin
            state_reg <= NVM_PROG;
          end else if (prog_req_i) begin
            prog_deny_o <= 1'b1;
          end else if (reload_req_i) begin
            state_reg <= NVM_RELOAD;
          end
        end
        NVM_PROG, NVM_RELOAD: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            state_reg     <= NVM_IDLE;
            prog_done_o   <= (state_reg == NVM_PROG);
            reload_done_o <= (state_reg == NVM_RELOAD);
          end
        end
        default: state_reg <= NVM_IDLE;
      endcase
    end
  end

  assign busy_o = (state_reg != NVM_IDLE);
endmodule : nvm_sequencer

// ---- cfg_regs.sv ----
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module cfg_regs
  import cfg_regs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dump_set_i,
  input  wire logic        dump_clear_i,
  input  wire logic [3:0]  thr_point_i,
  output logic [5:0]       thr_gain_mult_o,
  output logic             thr_long_range_o,
  output logic             echo_dump_enable_o,
  output logic [15:0]      bandpass_a2_o,
  output logic             nvm_busy_o,
  output logic             irq_o
);

  // ==========================================================================
  // Registers
  logic [7:0] preset2_gain_control_reg;
  logic [7:0] nvm_checksum_reg;
  logic       echo_dump_enable_reg;
  logic [3:0] nvm_unlock_code_reg;
  logic       nvm_write_success_reg;
  logic       nvm_reload_trigger_reg;
  logic       nvm_write_trigger_reg;
  logic [7:0] bandpass_a2_high_reg;
  logic [7:0] bandpass_a2_low_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_status_next;
  logic [3:0] irq_mask_reg;
  logic       ack_reg;

  logic       wr_go;
  logic       rd_go;
  logic       wr_lane0;
  logic       ctrl_wr;
  logic [7:0] wbyte;
  logic       prog_req;
  logic       reload_req;
  logic       prog_done;
  logic       prog_deny;
  logic       reload_done;
  logic       bad_gain;

  // ==========================================================================
  // Bus handshake: one wait cycle, then accept
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_go    = avs_write & ack_reg;
  assign rd_go    = avs_read & ack_reg;
  assign wr_lane0 = wr_go & avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction : hit

  assign ctrl_wr = wr_lane0 & hit(avs_address, IDX_NVM_CTRL);

  // ==========================================================================
  // Configuration bytes
  // Invalid gain codes are stored as written and flagged as an interrupt
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      preset2_gain_control_reg <= RESET_BYTE;
    end else if (wr_lane0 && hit(avs_address, IDX_GAIN_CTRL)) begin
      preset2_gain_control_reg <= wbyte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nvm_checksum_reg <= RESET_BYTE;
    end else if (wr_lane0 && hit(avs_address, IDX_CHECKSUM)) begin
      nvm_checksum_reg <= wbyte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bandpass_a2_high_reg <= RESET_BYTE;
    end else if (wr_lane0 && hit(avs_address, IDX_A2_HIGH)) begin
      bandpass_a2_high_reg <= wbyte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bandpass_a2_low_reg <= RESET_BYTE;
    end else if (wr_lane0 && hit(avs_address, IDX_A2_LOW)) begin
      bandpass_a2_low_reg <= wbyte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_mask_reg <= 4'h0;
    end else if (wr_lane0 && hit(avs_address, IDX_IRQ_MASK)) begin
      irq_mask_reg <= wbyte[3:0];
    end
  end

  // ==========================================================================
  // Memory control register
  // The unlock code is compared when the sequencer takes a trigger
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nvm_unlock_code_reg <= 4'h0;
    end else if (ctrl_wr) begin
      nvm_unlock_code_reg <= wbyte[UNLOCK_LSB +: 4];
    end
  end

  // Triggers clear once the sequencer takes them
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nvm_write_trigger_reg <= 1'b0;
    end else if (ctrl_wr) begin
      nvm_write_trigger_reg <= wbyte[PROGRAM_BIT];
    end else if (prog_req) begin
      nvm_write_trigger_reg <= 1'b0;
    end
  end

  // A pending reload waits while a program is taken first
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nvm_reload_trigger_reg <= 1'b0;
    end else if (ctrl_wr) begin
      nvm_reload_trigger_reg <= wbyte[RELOAD_BIT];
    end else if (reload_req && !prog_req) begin
      nvm_reload_trigger_reg <= 1'b0;
    end
  end

  // Hardware set/clear beside software write; hardware wins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      echo_dump_enable_reg <= 1'b0;
    end else if (dump_set_i) begin
      echo_dump_enable_reg <= 1'b1;
    end else if (dump_clear_i) begin
      echo_dump_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      echo_dump_enable_reg <= wbyte[DUMP_EN_BIT];
    end
  end

  // Success flag: set by a completed program, cleared by a new attempt
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nvm_write_success_reg <= 1'b0;
    end else if (prog_done) begin
      nvm_write_success_reg <= 1'b1;
    end else if (prog_req) begin
      nvm_write_success_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Program and reload sequencing
  assign prog_req   = nvm_write_trigger_reg & ~nvm_busy_o;
  assign reload_req = nvm_reload_trigger_reg & ~nvm_busy_o;

  nvm_sequencer u_seq (
    .core_clk_i    (core_clk_i),
    .srst_i        (srst_i),
    .prog_req_i    (prog_req),
    .reload_req_i  (reload_req),
    .unlocked_i    (nvm_unlock_code_reg == UNLOCK_PASSCODE),
    .busy_o        (nvm_busy_o),
    .prog_done_o   (prog_done),
    .prog_deny_o   (prog_deny),
    .reload_done_o (reload_done)
  );

  // ==========================================================================
  // Threshold gain selection
  gain_if gif ();
  assign gif.gain_ctrl = preset2_gain_control_reg;
  assign gif.thr_point = thr_point_i;

  gain_select u_gain (
    .g (gif.sel)
  );

  // Gain outputs lag the threshold point input by one cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      thr_gain_mult_o <= 6'h01;
    end else begin
      thr_gain_mult_o <= gif.mult;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      thr_long_range_o <= 1'b0;
    end else begin
      thr_long_range_o <= gif.long_range;
    end
  end

  assign bad_gain =
    (preset2_gain_control_reg[LR_GAIN_LSB +: 3] > GAIN_CODE_MAX) |
    (preset2_gain_control_reg[SR_GAIN_LSB +: 3] > GAIN_CODE_MAX);

  // ==========================================================================
  // Interrupts: set wins over write-one-to-clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_lane0 && hit(avs_address, IDX_IRQ_STATUS)) begin
      irq_status_next = irq_status_next & ~wbyte[3:0];
    end
    if (prog_done) begin
      irq_status_next[IRQ_PROG_DONE] = 1'b1;
    end
    if (prog_deny) begin
      irq_status_next[IRQ_PROG_DENY] = 1'b1;
    end
    if (reload_done) begin
      irq_status_next[IRQ_RELOAD_DONE] = 1'b1;
    end
    if (bad_gain) begin
      irq_status_next[IRQ_BAD_GAIN] = 1'b1;
    end
  end

  // The line is taken from the next status, so it rises in the same cycle as the status bit, one cycle after the event
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Outputs and read path
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      echo_dump_enable_o <= 1'b0;
    end else begin
      echo_dump_enable_o <= echo_dump_enable_reg;
    end
  end

  // Each coefficient byte reaches the filter one cycle after its own register is written
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bandpass_a2_o <= 16'h0000;
    end else begin
      bandpass_a2_o <= {bandpass_a2_high_reg, bandpass_a2_low_reg};
    end
  end

  // Loaded in the wait cycle, so the data stand when the request is accepted
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go || (avs_read && !ack_reg)) begin
      case (avs_address)
        IDX_GAIN_CTRL:  avs_readdata <= {24'h00_0000, preset2_gain_control_reg};
        IDX_CHECKSUM:   avs_readdata <= {24'h00_0000, nvm_checksum_reg};
        IDX_NVM_CTRL:   avs_readdata <= {24'h00_0000, echo_dump_enable_reg,
                                         nvm_unlock_code_reg,
                                         nvm_write_success_reg,
                                         nvm_reload_trigger_reg,
                                         nvm_write_trigger_reg};
        IDX_A2_HIGH:    avs_readdata <= {24'h00_0000, bandpass_a2_high_reg};
        IDX_A2_LOW:     avs_readdata <= {24'h00_0000, bandpass_a2_low_reg};
        IDX_IRQ_STATUS: avs_readdata <= {28'h000_0000, irq_status_reg};
        IDX_IRQ_MASK:   avs_readdata <= {28'h000_0000, irq_mask_reg};
        IDX_THR_POINT:  avs_readdata <= {26'h000_0000, thr_gain_mult_o};
        default:        avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : cfg_regs

// ---- cfg_regs_chk.sv ----
`timescale 1ns/10ps
module cfg_regs_chk
  import cfg_regs_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        dump_set_i,
  input wire logic        dump_clear_i,
  input wire logic [15:0] bandpass_a2_o,
  input wire logic        echo_dump_enable_o,
  input wire logic        nvm_busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // ==========================================================================
  // Accepted register writes
  logic acc;
  logic ctl;
  assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign ctl = acc && avs_address == IDX_NVM_CTRL && !nvm_busy_o;

  // ==========================================================================
  // Properties
  a_wait_first: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state on new request");
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  a_a2_high: assert property (
    acc && avs_address == IDX_A2_HIGH |->
    ##2 bandpass_a2_o[15:8] == $past(avs_writedata[7:0], 2))
    else $error("coefficient high byte not applied");
  a_a2_low: assert property (
    acc && avs_address == IDX_A2_LOW |->
    ##2 bandpass_a2_o[7:0] == $past(avs_writedata[7:0], 2))
    else $error("coefficient low byte not applied");
  a_prog_start: assert property (
    ctl && avs_writedata[6:3] == UNLOCK_PASSCODE && avs_writedata[0]
    |-> ##[1:3] nvm_busy_o)
    else $error("unlocked program did not start");
  a_locked_idle: assert property (
    ctl && avs_writedata[6:3] != UNLOCK_PASSCODE
    && avs_writedata[1:0] == 2'h1 |-> ##1 !nvm_busy_o [*4])
    else $error("locked program started");
  a_reload_start: assert property (
    ctl && avs_writedata[1] |-> ##[1:3] nvm_busy_o)
    else $error("reload did not start");
  a_busy_len: assert property (
    $rose(nvm_busy_o) |-> nvm_busy_o [*8])
    else $error("sequence shorter than eight cycles");
  a_dump_set: assert property (
    dump_set_i |-> ##2 echo_dump_enable_o)
    else $error("hardware set of dump enable lost");
  a_dump_clr: assert property (
    dump_clear_i && !dump_set_i |-> ##2 !echo_dump_enable_o)
    else $error("hardware clear of dump enable lost");
endmodule : cfg_regs_chk

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import cfg_regs_pkg::*;
  logic        core_clk_i, srst_i, avs_read, avs_write;
  logic        dump_set_i, dump_clear_i, avs_waitrequest;
  logic        thr_long_range_o, echo_dump_enable_o, nvm_busy_o, irq_o;
  logic [7:0]  avs_address, h, l, g;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, thr_point_i;
  logic [5:0]  thr_gain_mult_o;
  logic [15:0] bandpass_a2_o;
  logic [31:0] exp_q [$];
  logic [31:0] seed = 32'ha3ca_153c;
  logic [7:0]  regs [5] = '{IDX_GAIN_CTRL, IDX_CHECKSUM, IDX_NVM_CTRL,
                            IDX_A2_HIGH, IDX_A2_LOW};
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          k, p;

  cfg_regs uut (.core_clk_i, .srst_i, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .dump_set_i, .dump_clear_i, .thr_point_i, .thr_gain_mult_o,
    .thr_long_range_o, .echo_dump_enable_o, .bandpass_a2_o, .nvm_busy_o,
    .irq_o);

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick

  task automatic bus(input logic w, input logic [7:0] a, d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    tick(1);
  endtask : bus

  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wait_idle;
    while (nvm_busy_o !== 1'b0) @(posedge core_clk_i);
  endtask : wait_idle

  // ==========================================================================
  // Read monitor and timeout
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
    if (avs_read && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_q.pop_front(), "readdata");
  end

  // ==========================================================================
  // Main sequence
  initial begin
    srst_i = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    dump_set_i = 1'b0;
    dump_clear_i = 1'b0;
    thr_point_i = 4'h1;
    tick(6);
    srst_i <= 1'b0;
    check(thr_gain_mult_o, 6'h01, "reset mult");
    for (k = 0; k < 5; k++) rd(regs[k], 8'h00);
    rd(8'h10, 8'h00);
    // Byte registers and coefficient pairing
    h = 8'(xs());
    l = 8'(xs());
    bus(1'b1, IDX_A2_HIGH, h);
    bus(1'b1, IDX_A2_LOW, l);
    bus(1'b1, IDX_CHECKSUM, h ^ l);
    rd(IDX_A2_HIGH, h);
    rd(IDX_A2_LOW, l);
    check(bandpass_a2_o, {h, l}, "a2 value");
    bus(1'b1, 8'h10, h);
    rd(8'h10, 8'h00);
    avs_byteenable <= 4'h0;
    bus(1'b1, IDX_CHECKSUM, 8'h00);
    avs_byteenable <= 4'h1;
    rd(IDX_CHECKSUM, h ^ l);
    // Every gain code and every start point; codes stay in 0..5
    for (k = 0; k < 6; k++) begin
      g = {k[1:0], k[2:0], 3'(5 - k)};
      bus(1'b1, IDX_GAIN_CTRL, g);
      rd(IDX_GAIN_CTRL, g);
      for (p = 1; p <= 12; p++) begin
        thr_point_i <= p[3:0];
        tick(2);
        check(thr_long_range_o, p >= 9 + k % 4, "long");
        check(thr_gain_mult_o, 6'h01 << (p >= 9 + k % 4 ? k : 5 - k),
              "mult");
      end
    end
    rd(IDX_THR_POINT, 8'h20);
    // Locked program attempt, interrupt mask and clear
    bus(1'b1, IDX_NVM_CTRL, 8'h19);
    tick(3);
    check(nvm_busy_o, 1'h0, "locked busy");
    rd(IDX_NVM_CTRL, 8'h18);
    rd(IDX_IRQ_STATUS, 8'h02);
    check(irq_o, 1'h0, "irq masked");
    bus(1'b1, IDX_IRQ_MASK, 8'h0f);
    tick(1);
    check(irq_o, 1'h1, "irq raised");
    bus(1'b1, IDX_IRQ_STATUS, 8'h02);
    tick(1);
    check(irq_o, 1'h0, "irq cleared");
    // Unlocked program
    bus(1'b1, IDX_NVM_CTRL, 8'h69);
    tick(1);
    check(nvm_busy_o, 1'h1, "program busy");
    wait_idle;
    rd(IDX_NVM_CTRL, 8'h6c);
    rd(IDX_IRQ_STATUS, 8'h01);
    check(irq_o, 1'h1, "irq done");
    // Reload
    bus(1'b1, IDX_IRQ_STATUS, 8'hff);
    bus(1'b1, IDX_NVM_CTRL, 8'h6a);
    tick(1);
    check(nvm_busy_o, 1'h1, "reload busy");
    wait_idle;
    rd(IDX_NVM_CTRL, 8'h6c);
    rd(IDX_IRQ_STATUS, 8'h04);
    // Hardware and software control of dump enable
    dump_set_i <= 1'b1;
    tick(1);
    dump_set_i <= 1'b0;
    tick(2);
    check(echo_dump_enable_o, 1'h1, "dump set");
    rd(IDX_NVM_CTRL, 8'hec);
    dump_clear_i <= 1'b1;
    tick(1);
    dump_clear_i <= 1'b0;
    tick(2);
    check(echo_dump_enable_o, 1'h0, "dump clear");
    bus(1'b1, IDX_NVM_CTRL, 8'h80);
    rd(IDX_NVM_CTRL, 8'h84);
    // Reset in mid-run returns the control and coefficient registers to zero
    srst_i <= 1'b1;
    tick(2);
    srst_i <= 1'b0;
    check(echo_dump_enable_o, 1'h0, "reset dump");
    check(bandpass_a2_o, 16'h0000, "reset a2");
    rd(IDX_NVM_CTRL, 8'h00);
    rd(IDX_A2_HIGH, 8'h00);
    tick(2);
    end_of_test;
  end
endmodule : tb_top

bind cfg_regs cfg_regs_chk chk (.core_clk_i, .srst_i, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .dump_set_i, .dump_clear_i, .bandpass_a2_o, .echo_dump_enable_o,
  .nvm_busy_o);
